// *** shared/istx_pkg.sv ***
// Constants and carriers for the two-wire slave transmit block.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package istx_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SXC  = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_SADR = 8'h14;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SXC_RST   = 8'h08;
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [6:0] SADR_RST  = 7'h50;
  localparam int         SXC_EXT1  = 6;
  localparam int         SXC_EXT0  = 5;
  localparam int         SXC_ACC   = 4;
  localparam int         SXC_ONE   = 3;
  localparam int         ST_TRANSMIT_DATA_REQUEST_FLAG   = 3;
  localparam int         ST_TRANSMIT_READY_FLAG   = 2;
  localparam int         ST_TRANSMIT_EMPTY_FLAG   = 1;
  localparam int         ST_ACK    = 0;
  localparam int         MODE_MLS  = 3;
  localparam logic [3:0] ACK_CLK   = 4'h9;
  localparam logic [3:0] LAST_BIT  = 4'h8;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  localparam logic [1:0] RESP_DEC  = 2'h3;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       interface_enable;   // interface_enable
    logic       iei;   // bus_interrupt_enable
    logic       master_select;   // master_select
    logic       transmit_select;   // transmit_select
    logic       rsv;
    logic       bus_busy_flag;  // bus_busy_flag
    logic       bus_interrupt_flag;  // bus_interrupt_flag
    logic       rsv0;
  } istx_ctl_s;
  typedef enum logic [2:0] {
    SEL_SXC, SEL_CTRL, SEL_STAT, SEL_DATA, SEL_MODE, SEL_SADR, SEL_NONE
  } istx_sel_e;
  typedef enum {
    LS_IDLE, LS_ADDR, LS_AACK, LS_TX, LS_TACK, LS_SKIP
  } istx_state_e;
endpackage : istx_pkg
`default_nettype wire

// *** core/istx_core.sv ***
// Two-wire bus slave transmit path with serial extension control register.
// Assumes the bus master drives SCL; SCL/SDA/standby arrive asynchronously.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module istx_core (
  input  wire logic        clk_i,          // System clock, 50 MHz
  input  wire logic        rst_i,          // Synchronous reset, active high
  input  wire logic        hw_standby_i,   // Hardware standby pin, async
  input  wire logic [2:0]  cks_ch1_i,      // Clock select of the other channel
  input  wire logic [31:0] s_awaddr_i,     // AXI write address
  input  wire logic        s_awvalid_i,    // AXI write address valid
  output logic             s_awready_o,    // AXI write address ready
  input  wire logic [31:0] s_wdata_i,      // AXI write data
  input  wire logic [3:0]  s_wstrb_i,      // AXI write strobes
  input  wire logic        s_wvalid_i,     // AXI write data valid
  output logic             s_wready_o,     // AXI write data ready
  output logic [1:0]       s_bresp_o,      // AXI write response
  output logic             s_bvalid_o,     // AXI write response valid
  input  wire logic        s_bready_i,     // AXI write response ready
  input  wire logic [31:0] s_araddr_i,     // AXI read address
  input  wire logic        s_arvalid_i,    // AXI read address valid
  output logic             s_arready_o,    // AXI read address ready
  output logic [31:0]      s_rdata_o,      // AXI read data
  output logic [1:0]       s_rresp_o,      // AXI read response
  output logic             s_rvalid_o,     // AXI read valid
  input  wire logic        s_rready_i,     // AXI read ready
  input  wire logic        scl_i,          // SCL pin level
  output logic             scl_o,          // SCL drive value, always 0
  output logic             scl_oe_o,       // SCL pulled low while high
  input  wire logic        sda_i,          // SDA pin level
  output logic             sda_o,          // SDA drive value, always 0
  output logic             sda_oe_o,       // SDA pulled low while high
  output logic             irq_o,          // Interrupt request, level
  output logic [3:0]       rate_ch1_o,     // Master rate select, channel 1
  output logic [3:0]       rate_ch0_o      // Master rate select, channel 0
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Local names for the link states, so the engine reads without scoping
  localparam istx_pkg::istx_state_e LS_IDLE = istx_pkg::LS_IDLE;
  localparam istx_pkg::istx_state_e LS_ADDR = istx_pkg::LS_ADDR;
  localparam istx_pkg::istx_state_e LS_AACK = istx_pkg::LS_AACK;
  localparam istx_pkg::istx_state_e LS_TX   = istx_pkg::LS_TX;
  localparam istx_pkg::istx_state_e LS_TACK = istx_pkg::LS_TACK;
  localparam istx_pkg::istx_state_e LS_SKIP = istx_pkg::LS_SKIP;
  function automatic istx_pkg::istx_sel_e reg_sel(input logic [31:0] a);
    unique case (a[7:0])
      istx_pkg::OFS_SXC:  reg_sel = istx_pkg::SEL_SXC;
      istx_pkg::OFS_CTRL: reg_sel = istx_pkg::SEL_CTRL;
      istx_pkg::OFS_STAT: reg_sel = istx_pkg::SEL_STAT;
      istx_pkg::OFS_DATA: reg_sel = istx_pkg::SEL_DATA;
      istx_pkg::OFS_MODE: reg_sel = istx_pkg::SEL_MODE;
      istx_pkg::OFS_SADR: reg_sel = istx_pkg::SEL_SADR;
      default:            reg_sel = istx_pkg::SEL_NONE;
    endcase
    if (a[31:8] != 24'h000000) begin
      reg_sel = istx_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_sh;
  logic [2:0] sda_sh;
  logic [1:0] stby_sh;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sh  <= 3'h7;
      sda_sh  <= 3'h7;
      stby_sh <= 2'h0;
    end else begin
      scl_sh  <= {scl_sh[1:0], scl_i};
      sda_sh  <= {sda_sh[1:0], sda_i};
      stby_sh <= {stby_sh[0], hw_standby_i};
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_sh[1] & ~scl_sh[2];
  assign scl_fall   = ~scl_sh[1] & scl_sh[2];
  assign start_cond = scl_sh[1] & scl_sh[2] & ~sda_sh[1] & sda_sh[2];
  assign stop_cond  = scl_sh[1] & scl_sh[2] & sda_sh[1] & ~sda_sh[2];

  // ----------------------------------------------------------------
  // AXI4-Lite slave, one write and one read at a time
  // ----------------------------------------------------------------
  logic        aw_held, w_held;
  logic [31:0] aw_addr, w_data;
  logic [3:0]  w_strb;
  logic        wr_do, rd_do;
  istx_pkg::istx_sel_e wsel, rsel;
  assign wr_do = aw_held & w_held & ~s_bvalid_o;
  assign rd_do = s_arvalid_i & s_arready_o;
  assign wsel  = reg_sel(aw_addr);
  assign rsel  = reg_sel(s_araddr_i);

  logic [7:0]         sxc;
  istx_pkg::istx_ctl_s ctl;
  logic [7:0]         data_reg, shreg, mode, stat;
  logic [6:0]         sadr;
  logic               acc_en;
  assign acc_en = sxc[istx_pkg::SXC_ACC];

  // Bus registers other than the extension register need access enabled
  function automatic logic blocked(input istx_pkg::istx_sel_e s, input logic en);
    blocked = (s != istx_pkg::SEL_SXC) && (s != istx_pkg::SEL_NONE) && !en;
  endfunction : blocked

  logic wr_ok;
  assign wr_ok = wr_do & w_strb[0] & (wsel != istx_pkg::SEL_NONE)
                 & ~blocked(wsel, acc_en);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr     <= 32'h00000000;
      w_data      <= 32'h00000000;
      w_strb      <= 4'h0;
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= istx_pkg::RESP_OK;
    end else begin
      s_awready_o <= ~aw_held & ~s_awready_o & s_awvalid_i;
      s_wready_o  <= ~w_held & ~s_wready_o & s_wvalid_i;
      if (s_awvalid_i && s_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end
      if (wr_do) begin
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= (wsel == istx_pkg::SEL_NONE) ? istx_pkg::RESP_DEC :
                      blocked(wsel, acc_en) ? istx_pkg::RESP_SLV : istx_pkg::RESP_OK;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h00000000;
      s_rresp_o   <= istx_pkg::RESP_OK;
    end else begin
      s_arready_o <= ~s_arready_o & ~s_rvalid_o & s_arvalid_i;
      if (rd_do) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o  <= istx_pkg::RESP_OK;
        s_rdata_o  <= 32'h00000000;
        if (rsel == istx_pkg::SEL_NONE) begin
          s_rresp_o <= istx_pkg::RESP_DEC;
        end else if (blocked(rsel, acc_en)) begin
          s_rresp_o <= istx_pkg::RESP_SLV;
        end else begin
          unique case (rsel)
            istx_pkg::SEL_SXC:  s_rdata_o[7:0] <= sxc | istx_pkg::SXC_RST;
            istx_pkg::SEL_CTRL: s_rdata_o[7:0] <= ctl;
            istx_pkg::SEL_STAT: s_rdata_o[7:0] <= stat;
            istx_pkg::SEL_DATA: s_rdata_o[7:0] <= data_reg;
            istx_pkg::SEL_MODE: s_rdata_o[7:0] <= mode;
            default:            s_rdata_o[7:0] <= {sadr, 1'b0};
          endcase
        end
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Extension, mode and address registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || stby_sh[1]) begin
      sxc <= istx_pkg::SXC_RST;
    end else if (wr_ok && wsel == istx_pkg::SEL_SXC) begin
      sxc <= w_data[7:0] | istx_pkg::SXC_RST;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= 8'h00;
      sadr <= istx_pkg::SADR_RST;
    end else if (wr_ok && wsel == istx_pkg::SEL_MODE) begin
      mode <= w_data[7:0];
    end else if (wr_ok && wsel == istx_pkg::SEL_SADR) begin
      sadr <= w_data[7:1];
    end
  end
  // Extension bit picks between two prescaler tables for each channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_ch1_o <= 4'h0;
      rate_ch0_o <= 4'h0;
    end else begin
      rate_ch1_o <= {sxc[istx_pkg::SXC_EXT1], cks_ch1_i};
      rate_ch0_o <= {sxc[istx_pkg::SXC_EXT0], mode[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  istx_pkg::istx_state_e st;
  logic [3:0] bitn;
  logic [7:0] addr_sh;
  logic       stretch, load_ev, bus_interrupt_flag_set, data_wr, hit, lsb;
  assign lsb     = mode[istx_pkg::MODE_MLS];
  assign data_wr = wr_ok && wsel == istx_pkg::SEL_DATA;
  assign hit     = addr_sh[7:1] == sadr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= LS_IDLE;
      bitn     <= 4'h0;
      addr_sh  <= 8'h00;
      shreg    <= 8'hff;
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
      stretch  <= 1'b0;
      load_ev  <= 1'b0;
      bus_interrupt_flag_set <= 1'b0;
      sda_o    <= 1'b0;
      scl_o    <= 1'b0;
    end else begin
      load_ev  <= 1'b0;
      bus_interrupt_flag_set <= 1'b0;
      if (!ctl.interface_enable || ctl.master_select || stop_cond) begin
        st       <= LS_IDLE;
        sda_oe_o <= 1'b0;
        scl_oe_o <= 1'b0;
        stretch  <= 1'b0;
      end else if (start_cond) begin
        st       <= LS_ADDR;
        bitn     <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stretch) begin
        // Clock held low until software supplies the next byte
        if (data_wr) begin
          stretch  <= 1'b0;
          scl_oe_o <= 1'b0;
          shreg    <= lsb ? {1'b1, w_data[7:1]} : {w_data[6:0], 1'b1};
          sda_oe_o <= ~(lsb ? w_data[0] : w_data[7]);
          load_ev  <= 1'b1;
          st       <= LS_TX;
          bitn     <= 4'h0;
        end
      end else begin
        unique case (st)
          LS_IDLE, LS_SKIP: begin
          end
          LS_ADDR: begin
            if (scl_rise) begin
              addr_sh <= {addr_sh[6:0], sda_sh[1]};
              bitn    <= bitn + 4'h1;
            end else if (scl_fall && bitn == istx_pkg::LAST_BIT) begin
              if (hit) begin
                sda_oe_o <= 1'b1;
                st       <= LS_AACK;
              end else begin
                st <= LS_SKIP;
              end
            end
          end
          LS_AACK: begin
            if (scl_rise) begin
              bus_interrupt_flag_set <= 1'b1;
            end else if (scl_fall) begin
              sda_oe_o <= 1'b0;
              if (addr_sh[0]) begin
                scl_oe_o <= 1'b1;
                stretch  <= 1'b1;
              end else begin
                st <= LS_SKIP;
              end
            end
          end
          LS_TX: begin
            if (scl_fall) begin
              bitn <= bitn + 4'h1;
              if (bitn == 4'h7) begin
                sda_oe_o <= 1'b0;
                st       <= LS_TACK;
              end else begin
                sda_oe_o <= ~(lsb ? shreg[0] : shreg[7]);
                shreg    <= lsb ? {1'b1, shreg[7:1]} : {shreg[6:0], 1'b1};
              end
            end
          end
          default: begin
            if (scl_rise) begin
              bus_interrupt_flag_set <= 1'b1;
            end else if (scl_fall) begin
              if (stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG]) begin
                scl_oe_o <= 1'b1;
                stretch  <= 1'b1;
              end else begin
                shreg    <= lsb ? {1'b1, data_reg[7:1]} : {data_reg[6:0], 1'b1};
                sda_oe_o <= ~(lsb ? data_reg[0] : data_reg[7]);
                load_ev  <= 1'b1;
                st       <= LS_TX;
                bitn     <= 4'h0;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, status and data registers
  // ----------------------------------------------------------------
  logic ack_ev;
  assign ack_ev = (st == LS_TACK) & scl_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl      <= '0;
      stat     <= 8'h00;
      data_reg <= istx_pkg::DATA_RST;
    end else begin
      if (wr_ok && wsel == istx_pkg::SEL_CTRL) begin
        ctl.interface_enable <= w_data[7];
        ctl.iei <= w_data[6];
        ctl.master_select <= w_data[5];
        ctl.transmit_select <= w_data[4];
        ctl.rsv <= w_data[3];
        // Write 0 clears, write 1 leaves the flag alone
        if (!w_data[1]) begin
          ctl.bus_interrupt_flag <= 1'b0;
        end
      end
      if (wr_ok && wsel == istx_pkg::SEL_STAT) begin
        if (!w_data[istx_pkg::ST_TRANSMIT_DATA_REQUEST_FLAG]) begin
          stat[istx_pkg::ST_TRANSMIT_DATA_REQUEST_FLAG] <= 1'b0;
        end
        if (!w_data[istx_pkg::ST_TRANSMIT_READY_FLAG]) begin
          stat[istx_pkg::ST_TRANSMIT_READY_FLAG] <= 1'b0;
        end
      end
      if (data_wr) begin
        data_reg                <= w_data[7:0];
        stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG] <= 1'b0;
      end
      // Hardware sets come last so they win over a same-cycle clear
      if (start_cond) begin
        ctl.bus_busy_flag <= 1'b1;
      end
      if (stop_cond) begin
        ctl.bus_busy_flag <= 1'b0;
      end
      if (bus_interrupt_flag_set || load_ev) begin
        ctl.bus_interrupt_flag <= 1'b1;
      end
      if (st == LS_AACK && scl_fall && addr_sh[0]) begin
        ctl.transmit_select                 <= 1'b1;
        stat[istx_pkg::ST_TRANSMIT_DATA_REQUEST_FLAG] <= 1'b1;
        stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG] <= 1'b1;
      end
      if (load_ev) begin
        stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG] <= 1'b1;
        stat[istx_pkg::ST_TRANSMIT_READY_FLAG] <= 1'b1;
      end
      if (ack_ev) begin
        stat[istx_pkg::ST_ACK] <= sda_sh[1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ctl.bus_interrupt_flag & ctl.iei;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_frame_end;
    st == LS_TACK && scl_fall && !stretch && !stop_cond && !start_cond && ctl.interface_enable && !ctl.master_select;
  endsequence
  AST_SXC_STBY: assert property (stby_sh[1] |=> sxc == istx_pkg::SXC_RST)
    else $error("extension register not reset in standby");
  AST_BLOCK_WR: assert property ((wr_do && !acc_en && wsel == istx_pkg::SEL_DATA)
    |=> $stable(data_reg) && s_bresp_o == istx_pkg::RESP_SLV)
    else $error("blocked write reached a bus register");
  AST_RATE0: assert property (##1 rate_ch0_o == {$past(sxc[istx_pkg::SXC_EXT0]), $past(mode[2:0])})
    else $error("channel 0 rate select wrong");
  AST_BIT3: assert property (sxc[istx_pkg::SXC_ONE])
    else $error("reserved bit 3 not one");
  AST_ADDR_ACK: assert property ((st == LS_ADDR && scl_fall && bitn == istx_pkg::LAST_BIT
    && hit && ctl.interface_enable && !ctl.master_select && !stop_cond && !start_cond && !stretch)
    |=> sda_oe_o && st == LS_AACK)
    else $error("no acknowledge on address match");
  AST_IRQ: assert property ($rose(ctl.bus_interrupt_flag) && ctl.iei |=> irq_o)
    else $error("interrupt not raised");
  AST_ENTER_TX: assert property ((st == LS_AACK && scl_fall && addr_sh[0] && ctl.interface_enable && !ctl.master_select
    && !stop_cond && !start_cond && !stretch)
    |=> ctl.transmit_select && stat[istx_pkg::ST_TRANSMIT_DATA_REQUEST_FLAG] && scl_oe_o && stretch)
    else $error("transmit mode not entered");
  AST_HOLD: assert property (stretch && !data_wr && !stop_cond && ctl.interface_enable && !ctl.master_select
    |=> scl_oe_o)
    else $error("clock released without data");
  AST_LOAD: assert property (stretch && data_wr && ctl.interface_enable && !ctl.master_select && !stop_cond && !start_cond
    |=> load_ev ##1 stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG] && ctl.bus_interrupt_flag && stat[istx_pkg::ST_TRANSMIT_READY_FLAG])
    else $error("flags not set after load");
  AST_NINTH: assert property ((st == LS_TACK && scl_rise && !stretch && ctl.interface_enable && !ctl.master_select
    && !stop_cond && !start_cond) |=> ##1 ctl.bus_interrupt_flag)
    else $error("flag not set at ninth clock");
  AST_STRETCH: assert property (s_frame_end and stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG]
    |=> scl_oe_o)
    else $error("no stretch with empty buffer");
  AST_ACK_STATUS_BIT: assert property (ack_ev && ctl.interface_enable |=> stat[istx_pkg::ST_ACK] == $past(sda_sh[1]))
    else $error("master acknowledge not stored");
  AST_NEXT: assert property (s_frame_end and !stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG]
    |=> st == LS_TX && load_ev ##1 stat[istx_pkg::ST_TRANSMIT_EMPTY_FLAG])
    else $error("pending byte not loaded");
  AST_STOP: assert property (stop_cond |=> !ctl.bus_busy_flag && st == LS_IDLE)
    else $error("stop not detected");
endmodule : istx_core
`default_nettype wire

// *** tb/istx_master.sv ***
// Two-wire bus master model that clocks bytes out of the slave.
// Assumes the bench resolves both lines as open drain with pull-ups.
`default_nettype none
module istx_master (
  input  wire logic scl_i,     // Resolved SCL level
  input  wire logic sda_i,     // Resolved SDA level
  output logic      scl_oe_o,  // Pull SCL low
  output logic      sda_oe_o   // Pull SDA low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 80;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic start();
    sda_oe_o = 1'b1;
    #HALF;
    scl_oe_o = 1'b1;
  endtask : start
  // Nine clocks; the ninth carries ack unless rel9 leaves SDA released
  task automatic xfer(input logic [7:0] tx, input logic rel9, output logic [7:0] rx,
                      output logic ack);
    for (int i = 0; i < 9; i++) begin
      #(HALF / 2);
      sda_oe_o = (i < 8) ? ~tx[7 - i] : ~rel9;
      #(HALF / 2);
      scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #(HALF / 2);
      if (i < 8) rx[7 - i] = sda_i;
      else ack = sda_i;
      #(HALF / 2);
      scl_oe_o = 1'b1;
    end
    sda_oe_o = 1'b0;
  endtask : xfer
  task automatic stop();
    sda_oe_o = 1'b1;
    #HALF;
    scl_oe_o = 1'b0;
    wait (scl_i === 1'b1);
    #HALF;
    sda_oe_o = 1'b0;
    #HALF;
  endtask : stop
endmodule : istx_master
`default_nettype wire

// *** tb/istx_core_tb.sv ***
// Bench for the slave transmit path: AXI4-Lite register tasks plus a bus master model.
// Assumes a 50 MHz clock and pull-ups on both link lines.
`default_nettype none
module istx_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, stby = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic        arv = 1'b0, rready = 1'b0, awr, wrdy, bv, arr, rv, scl_oe, sda_oe, irq, ack;
  logic        m_scl_oe, m_sda_oe;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  rate1, rate0;
  logic [7:0]  rx;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  wire         scl = ~(scl_oe | m_scl_oe);
  wire         sda = ~(sda_oe | m_sda_oe);
  always #10 clk_i = ~clk_i;
  istx_core u_istx_core (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(stby), .cks_ch1_i(3'h2),
    .s_awaddr_i(awaddr), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wdata),
    .s_wstrb_i(4'hf), .s_wvalid_i(wv), .s_wready_o(wrdy), .s_bresp_o(bresp), .s_bvalid_o(bv),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arv), .s_arready_o(arr),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rv), .s_rready_i(rready), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq),
    .rate_ch1_o(rate1), .rate_ch0_o(rate0));
  istx_master u_istx_master (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk_i);
    awaddr <= {24'h0, a};
    wdata  <= {24'h0, d};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(r));
  endtask : wchk
  // Only the bits under the mask are compared
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                      input logic [1:0] r);
    @(posedge clk_i);
    araddr <= {24'h0, a};
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rready <= 1'b0;
    chk(rdata & {24'h0, m}, {24'h0, e});
    chk(32'(rresp), 32'(r));
  endtask : rchk
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(istx_pkg::OFS_SXC, 8'h08, 8'hff, istx_pkg::RESP_OK);
    rchk(istx_pkg::OFS_CTRL, 8'h00, 8'hff, istx_pkg::RESP_SLV);
    wchk(istx_pkg::OFS_DATA, 8'h11, istx_pkg::RESP_SLV);
    rchk(8'h40, 8'h00, 8'hff, istx_pkg::RESP_DEC);
    wchk(istx_pkg::OFS_SXC, 8'h70, istx_pkg::RESP_OK);
    @(posedge clk_i) stby <= 1'b1;
    repeat (6) @(posedge clk_i);
    stby <= 1'b0;
    rchk(istx_pkg::OFS_SXC, 8'h08, 8'hff, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_SXC, 8'h70, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_MODE, 8'h05, istx_pkg::RESP_OK);
    rchk(istx_pkg::OFS_DATA, 8'hff, 8'hff, istx_pkg::RESP_OK);
    rchk(istx_pkg::OFS_SXC, 8'h78, 8'hff, istx_pkg::RESP_OK);
    chk(32'(rate1), 32'h0a);
    chk(32'(rate0), 32'h0d);
    wchk(istx_pkg::OFS_CTRL, 8'hc0, istx_pkg::RESP_OK);
    u_istx_master.start();
    u_istx_master.xfer(8'ha1, 1'b1, rx, ack);
    chk(32'(ack), 32'h0);
    repeat (8) @(posedge clk_i);
    chk(32'(scl_oe), 32'h1);
    chk(32'(irq), 32'h1);
    rchk(istx_pkg::OFS_CTRL, 8'hd6, 8'hff, istx_pkg::RESP_OK);
    rchk(istx_pkg::OFS_STAT, 8'h0a, 8'h0b, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_CTRL, 8'hc0, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_DATA, 8'ha5, istx_pkg::RESP_OK);
    repeat (4) @(posedge clk_i);
    chk(32'(scl_oe), 32'h0);
    rchk(istx_pkg::OFS_STAT, 8'h06, 8'h06, istx_pkg::RESP_OK);
    rchk(istx_pkg::OFS_CTRL, 8'h02, 8'h02, istx_pkg::RESP_OK);
    // Second byte is queued while the first is on the wire, so no stretch between them
    fork
      u_istx_master.xfer(8'hff, 1'b0, rx, ack);
      begin
        wchk(istx_pkg::OFS_CTRL, 8'hc0, istx_pkg::RESP_OK);
        wchk(istx_pkg::OFS_DATA, 8'h3c, istx_pkg::RESP_OK);
      end
    join
    chk(32'(rx), 32'ha5);
    u_istx_master.xfer(8'hff, 1'b0, rx, ack);
    chk(32'(rx), 32'h3c);
    repeat (8) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    chk(32'(scl_oe), 32'h1);
    rchk(istx_pkg::OFS_STAT, 8'h00, 8'h01, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_CTRL, 8'hc0, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_DATA, 8'hff, istx_pkg::RESP_OK);
    u_istx_master.xfer(8'hff, 1'b1, rx, ack);
    chk(32'(rx), 32'hff);
    rchk(istx_pkg::OFS_STAT, 8'h01, 8'h01, istx_pkg::RESP_OK);
    wchk(istx_pkg::OFS_DATA, 8'hff, istx_pkg::RESP_OK);
    u_istx_master.stop();
    rchk(istx_pkg::OFS_CTRL, 8'h00, 8'h04, istx_pkg::RESP_OK);
    chk(32'(sda_oe), 32'h0);
    end_of_test();
  end
endmodule : istx_core_tb
`default_nettype wire
